//--- rtl/frp_read_port.sv
// fifo read port: resets, reads, chip select, retransmit and offset access
// Behaviour
// - partial reset zeroes pointers and output register
// - partial reset keeps modes and flag offsets
// - output is 36, 18 or 9 bits
// - sync mode reads on enabled read-clock rise
// - load low presents offset registers instead
// - async mode reads on each strobe rise
// - chip select sampled, gates reads and drive
// - during resets output enable alone drives outputs
// - retransmit resets read pointer, shows empty
// - retransmit leaves write pointer and settings
// - retransmit returns to marked location if set
// - enabled serial clock rise shifts offset bit
// - mark captures current read pointer
// - mode pin becomes serial data after reset
`timescale 1ns/1ps
`default_nettype none
module frp_read_port (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // device resets
    input wire logic master_reset_n_in,
    input wire logic partial_reset_n_in,
    // configuration pins sampled during master reset
    input wire logic fall_through_mode_in,
    input wire logic async_read_in,
    input wire logic [1:0] read_width_in,
    // read port
    input wire logic read_clock_in,
    input wire logic read_enable_n_in,
    input wire logic read_select_n_in,
    input wire logic output_enable_n_in,
    input wire logic retransmit_in,
    input wire logic mark_in,
    input wire logic offset_access_n_in,
    output logic [frp_pkg::DATA_W-1:0] read_data_out,
    output logic read_data_oe_out,
    // serial offset loading
    input wire logic serial_clock_in,
    input wire logic offset_shift_enable_n_in,
    // write side from logic on ref_clk_in
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire logic [frp_pkg::DATA_W-1:0] wr_data_in,
    // flags
    output logic empty_flag_n_out,
    output logic full_flag_n_out,
    output logic almost_empty_n_out,
    output logic almost_full_n_out
);
    import frp_pkg::*;

    typedef struct packed {
        logic rclk_p;
        logic sclk_p;
        logic mark_p;
        logic fall_through_mode;
        logic async_rd;
        logic serial_pgm;
        logic [1:0] width;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W-1:0] mark_ptr;
        logic mark_valid;
        logic [CNT_W-1:0] count;
        logic [1:0] sub;
        logic out_valid;
        logic force_empty;
        logic ofs_sel;
        logic cs_n;
        logic [OFS_W-1:0] empty_ofs;
        logic [OFS_W-1:0] full_ofs;
        logic [DATA_W-1:0] dout;
    } frp_state_type;

    localparam frp_state_type STATE_RST = '{
        cs_n: 1'b1, empty_ofs: EMPTY_OFS_RST, full_ofs: FULL_OFS_RST, default: '0};

    frp_state_type q, d;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [PIN_W-1:0] pins;
    logic [PIN_W-1:0] s;
    logic stage_valid;
    logic [DATA_W-1:0] stage_data;
    logic write_ok;
    logic in_reset, rclk_rise, sclk_rise, mark_rise;
    logic read_ev, ofs_ev, fifo_ev, retx_ev, take, last, shift_ev;
    logic [DATA_W-1:0] word;
    logic [DATA_W-1:0] chunk;
    logic [PTR_W-1:0] target;

    assign pins = {read_width_in, async_read_in, partial_reset_n_in, master_reset_n_in,
                   offset_shift_enable_n_in, offset_access_n_in, output_enable_n_in,
                   read_select_n_in, read_enable_n_in, retransmit_in, mark_in,
                   fall_through_mode_in, serial_clock_in, read_clock_in};

    frp_sync #(.W(PIN_W)) u_sync (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .pin_in(pins),
        .sync_out(s)
    );

    frp_stage_fifo #(.W(DATA_W), .D(STAGE_DEPTH)) u_stage (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .flush_in(in_reset),
        .in_valid_in(wr_valid_in),
        .in_ready_out(wr_ready_out),
        .in_data_in(wr_data_in),
        .out_valid_out(stage_valid),
        .out_ready_in(write_ok),
        .out_data_out(stage_data)
    );

    always_comb begin
        d = q;
        in_reset = !s[PIN_MRST] || !s[PIN_PRST];
        rclk_rise = s[PIN_RCLK] && !q.rclk_p;
        sclk_rise = s[PIN_SCLK] && !q.sclk_p;
        mark_rise = s[PIN_MARK] && !q.mark_p;
        d.rclk_p = s[PIN_RCLK];
        d.sclk_p = s[PIN_SCLK];
        d.mark_p = s[PIN_MARK];
        // async mode ignores read enable; sync mode needs it low
        read_ev = rclk_rise && !in_reset && !s[PIN_RCS]
                  && (q.async_rd || !s[PIN_REN]);
        ofs_ev = read_ev && !s[PIN_LD];
        fifo_ev = read_ev && s[PIN_LD];
        retx_ev = rclk_rise && !in_reset && !s[PIN_RCS] && s[PIN_RT];
        write_ok = stage_valid && (q.count != CNT_FULL) && !in_reset && s[PIN_LD];
        word = mem[q.rd_ptr];
        unique case (q.width)
            WIDTH_18: begin
                chunk = {18'h0, q.sub[0] ? word[35:18] : word[17:0]};
                last = (q.sub == SUB_LAST_18);
            end
            WIDTH_9: begin
                chunk = {27'h0, word[9*q.sub +: 9]};
                last = (q.sub == SUB_LAST_9);
            end
            default: begin
                chunk = word;
                last = 1'b1;
            end
        endcase
        if (q.fall_through_mode) begin
            take = (!q.out_valid || fifo_ev) && (q.count != '0) && !retx_ev;
        end else begin
            take = fifo_ev && (q.count != '0) && !q.force_empty && !retx_ev;
        end
        d.force_empty = 1'b0;
        if (take) begin
            d.dout = chunk;
            d.out_valid = 1'b1;
            if (last) begin
                d.rd_ptr = (q.rd_ptr == PTR_LAST) ? '0 : q.rd_ptr + 1'b1;
                d.sub = 2'h0;
            end else begin
                d.sub = q.sub + 2'h1;
            end
        end else if (q.fall_through_mode && fifo_ev) begin
            d.out_valid = 1'b0;
        end
        if (ofs_ev) begin
            d.dout = {26'h0, q.ofs_sel ? q.full_ofs : q.empty_ofs};
            d.ofs_sel = !q.ofs_sel;
        end
        if (write_ok) begin
            d.wr_ptr = (q.wr_ptr == PTR_LAST) ? '0 : q.wr_ptr + 1'b1;
        end
        d.count = q.count + CNT_W'(write_ok) - CNT_W'(take && last);
        target = q.mark_valid ? q.mark_ptr : '0;
        if (retx_ev) begin
            // only the read side moves; write pointer and settings stay
            d.rd_ptr = target;
            d.sub = 2'h0;
            d.out_valid = 1'b0;
            d.force_empty = !q.fall_through_mode;
            d.count = {1'b0, d.wr_ptr - target};
        end
        if (mark_rise && !in_reset) begin
            d.mark_ptr = q.rd_ptr;
            d.mark_valid = 1'b1;
        end
        if (rclk_rise && !in_reset) begin
            d.cs_n = s[PIN_RCS];
        end
        // the mode pin doubles as serial data once master reset is over
        shift_ev = sclk_rise && !s[PIN_SEN] && q.serial_pgm && !in_reset;
        if (shift_ev) begin
            {d.empty_ofs, d.full_ofs} = {q.empty_ofs[OFS_W-2:0], q.full_ofs,
                                         s[PIN_SI]};
        end
        if (!s[PIN_PRST] || !s[PIN_MRST]) begin
            d.wr_ptr = '0;
            d.rd_ptr = '0;
            d.count = '0;
            d.dout = '0;
            d.sub = 2'h0;
            d.out_valid = 1'b0;
            d.mark_valid = 1'b0;
            d.force_empty = 1'b0;
            d.ofs_sel = 1'b0;
            d.cs_n = 1'b1;
        end
        if (!s[PIN_MRST]) begin
            // partial reset alone never reaches these fields
            d.fall_through_mode = s[PIN_SI];
            d.async_rd = s[PIN_ASYNC];
            d.serial_pgm = !s[PIN_LD];
            d.width = {s[PIN_WID1], s[PIN_WID0]};
            d.empty_ofs = EMPTY_OFS_RST;
            d.full_ofs = FULL_OFS_RST;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (write_ok) begin
            mem[q.wr_ptr] <= stage_data;
        end
    end

    assign read_data_out = q.dout;
    assign read_data_oe_out = !s[PIN_OE] && (in_reset || !q.cs_n);
    assign empty_flag_n_out = q.fall_through_mode ? !q.out_valid : !((q.count == '0) || q.force_empty);
    assign full_flag_n_out = (q.count != CNT_FULL);
    assign almost_empty_n_out = (q.count >= CNT_W'(q.empty_ofs));
    assign almost_full_n_out = ((CNT_FULL - q.count) > CNT_W'(q.full_ofs));

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    property p_prst_clear;
        !s[PIN_PRST] |=> (q.rd_ptr == '0) && (q.wr_ptr == '0) && (read_data_out == '0);
    endproperty
    a_prst_clear: assert property (p_prst_clear) else $error("partial reset left data");

    property p_prst_keep;
        (!s[PIN_PRST] && s[PIN_MRST]) |=> $stable(q.fall_through_mode) && $stable(q.serial_pgm)
                                          && $stable(q.empty_ofs) && $stable(q.width);
    endproperty
    a_prst_keep: assert property (p_prst_keep) else $error("partial reset lost settings");

    property p_narrow;
        (q.width == WIDTH_9) |-> (read_data_out[35:9] == '0);
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow output upper bits set");

    property p_read_adv;
        (fifo_ev && !q.fall_through_mode && !retx_ev && (q.count != '0) && !q.force_empty && last)
            |=> (q.rd_ptr != $past(q.rd_ptr)) && (q.count == $past(q.count) - 11'h1
                                                  + CNT_W'($past(write_ok)));
    endproperty
    a_read_adv: assert property (p_read_adv) else $error("read did not advance");

    property p_ofs_out;
        ofs_ev |=> read_data_out[OFS_W-1:0] == $past(q.ofs_sel ? q.full_ofs : q.empty_ofs);
    endproperty
    a_ofs_out: assert property (p_ofs_out) else $error("offset read wrong");

    property p_async_read;
        (q.async_rd && rclk_rise && !in_reset && !s[PIN_RCS] && s[PIN_LD]) |-> fifo_ev;
    endproperty
    a_async_read: assert property (p_async_read) else $error("strobe read missed");

    property p_deselect;
        (q.cs_n && !in_reset) |-> !read_data_oe_out;
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselected port active");

    property p_desel_read;
        s[PIN_RCS] |-> !read_ev && !retx_ev;
    endproperty
    a_desel_read: assert property (p_desel_read) else $error("deselected read taken");

    property p_reset_drive;
        (in_reset && !s[PIN_OE]) |-> read_data_oe_out;
    endproperty
    a_reset_drive: assert property (p_reset_drive) else $error("reset drive wrong");

    property p_retx;
        (retx_ev && !mark_rise) |=> (q.rd_ptr == $past(target)) && (q.sub == 2'h0)
                                    && (q.fall_through_mode ? empty_flag_n_out : !empty_flag_n_out);
    endproperty
    a_retx: assert property (p_retx) else $error("retransmit failed");

    property p_retx_wr;
        retx_ev && s[PIN_MRST] && s[PIN_PRST] |=> ((q.wr_ptr == $past(q.wr_ptr))
            || $past(write_ok)) && $stable(q.fall_through_mode) && $stable(q.full_ofs);
    endproperty
    a_retx_wr: assert property (p_retx_wr) else $error("retransmit moved write side");

    property p_shift;
        shift_ev && s[PIN_MRST] |=> (q.full_ofs[0] == $past(s[PIN_SI]))
                                    && (q.full_ofs[OFS_W-1:1] == $past(q.full_ofs[OFS_W-2:0]));
    endproperty
    a_shift: assert property (p_shift) else $error("serial shift wrong");

    property p_mark;
        (mark_rise && !in_reset) |=> q.mark_valid && (q.mark_ptr == $past(q.rd_ptr));
    endproperty
    a_mark: assert property (p_mark) else $error("mark not captured");

    property p_wrap;
        (take && last && !ofs_ev && (q.rd_ptr == PTR_LAST) && !in_reset) |=> (q.rd_ptr == '0);
    endproperty
    a_wrap: assert property (p_wrap) else $error("read pointer did not wrap");
endmodule : frp_read_port
`default_nettype wire

//--- rtl/frp_pkg.sv
// constants shared by the fifo read port design
package frp_pkg;
    localparam int DATA_W = 36;
    localparam int DEPTH = 1024;
    localparam int PTR_W = 10;
    localparam int CNT_W = 11;
    localparam int OFS_W = 10;
    localparam logic [PTR_W-1:0] PTR_LAST = 10'h3FF;
    localparam logic [CNT_W-1:0] CNT_FULL = 11'h400;
    localparam logic [OFS_W-1:0] EMPTY_OFS_RST = 10'h07F;
    localparam logic [OFS_W-1:0] FULL_OFS_RST = 10'h07F;
    localparam int STAGE_DEPTH = 8;
    // read width codes on read_width_in
    localparam logic [1:0] WIDTH_36 = 2'h0;
    localparam logic [1:0] WIDTH_18 = 2'h1;
    localparam logic [1:0] WIDTH_9 = 2'h2;
    localparam logic [1:0] SUB_LAST_18 = 2'h1;
    localparam logic [1:0] SUB_LAST_9 = 2'h3;
    // bit positions in the synchronised pin vector
    localparam int PIN_RCLK = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_SI = 2;
    localparam int PIN_MARK = 3;
    localparam int PIN_RT = 4;
    localparam int PIN_REN = 5;
    localparam int PIN_RCS = 6;
    localparam int PIN_OE = 7;
    localparam int PIN_LD = 8;
    localparam int PIN_SEN = 9;
    localparam int PIN_MRST = 10;
    localparam int PIN_PRST = 11;
    localparam int PIN_ASYNC = 12;
    localparam int PIN_WID0 = 13;
    localparam int PIN_WID1 = 14;
    localparam int PIN_W = 15;
endpackage : frp_pkg

//--- rtl/frp_sync.sv
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module frp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // pins and their synchronised copy
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } frp_sync_state_type;

    frp_sync_state_type q, d;

    always_comb begin
        d = q;
        d.first = pin_in;
        d.second = q.first;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_out = q.second;
endmodule : frp_sync
`default_nettype wire

//--- rtl/frp_stage_fifo.sv
// small staging fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module frp_stage_fifo #(
    parameter int W = 36,
    parameter int D = 8
) (
    // clock, reset and flush
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic flush_in,
    // fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    // drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);
    localparam logic [CW-1:0] CNT_D = CW'(D);
    localparam logic [AW-1:0] ADDR_LAST = AW'(D - 1);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
    } frp_stage_state_type;

    frp_stage_state_type q, d;
    logic [W-1:0] mem [D];
    logic push;
    logic pop;

    always_comb begin
        d = q;
        push = in_valid_in && (q.cnt != CNT_D);
        pop = out_ready_in && (q.cnt != '0);
        if (push) begin
            d.wr = (q.wr == ADDR_LAST) ? '0 : q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = (q.rd == ADDR_LAST) ? '0 : q.rd + 1'b1;
        end
        d.cnt = q.cnt + CW'(push) - CW'(pop);
        if (flush_in) begin
            d = '0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem[q.wr] <= in_data_in;
        end
    end

    assign in_ready_out = (q.cnt != CNT_D);
    assign out_valid_out = (q.cnt != '0);
    assign out_data_out = mem[q.rd];
endmodule : frp_stage_fifo
`default_nettype wire

//--- testbench/frp_reader_model.sv
// far-side reader: read clock pulses, enables, select and word capture
`timescale 1ns/1ps
`default_nettype none
module frp_reader_model (
    // clock and latched port mode
    input wire logic ref_clk_in,
    input wire logic async_in,
    // read port pins
    output logic read_clock_out,
    output logic read_enable_n_out,
    output logic read_select_n_out,
    output logic retransmit_out,
    output logic offset_access_n_out,
    // returned word
    input wire logic [frp_pkg::DATA_W-1:0] read_data_in
);
    import frp_pkg::*;
    initial begin
        read_clock_out = 1'b0;
        read_enable_n_out = 1'b1;
        read_select_n_out = 1'b1;
        retransmit_out = 1'b0;
        offset_access_n_out = 1'b1;
    end
    // each clock level is held 4 cycles so the pin synchroniser never drops an edge
    task automatic read(input logic en_n, input logic sel_n, input logic rt, input logic ofs_n,
                        output logic [DATA_W-1:0] q);
        @(posedge ref_clk_in);
        read_enable_n_out <= async_in ? 1'b0 : en_n;
        read_select_n_out <= sel_n;
        retransmit_out <= rt;
        offset_access_n_out <= ofs_n;
        repeat (2) @(posedge ref_clk_in);
        read_clock_out <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        read_clock_out <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        q = read_data_in;
        read_enable_n_out <= async_in ? 1'b0 : 1'b1;
        retransmit_out <= 1'b0;
        offset_access_n_out <= 1'b1;
    endtask : read
endmodule : frp_reader_model
`default_nettype wire

//--- testbench/frp_read_port_tb.sv
// self-checking bench for the fifo read port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin errors++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end
module frp_read_port_tb;
    import frp_pkg::*;
    typedef struct packed {
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
    } frp_row_type;
    localparam frp_row_type ROWS [4] = '{'{36'h0_0000_0000, 36'h0_0000_0000},
        '{36'hF_FFFF_FFFF, 36'hF_FFFF_FFFF}, '{36'hA_5A5A_5A5A, 36'hA_5A5A_5A5A},
        '{36'h1_2345_6789, 36'h1_2345_6789}};
    localparam logic [2:0] MODES [3] = '{{1'b0, WIDTH_18}, {1'b0, WIDTH_9}, {1'b1, WIDTH_36}};
    localparam logic [19:0] SER = {10'h002, 10'h0AA};
    localparam logic [DATA_W-1:0] WORD = 36'h9_8765_4321;
    localparam logic L = 1'b0;
    localparam logic H = 1'b1;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic mrst_n = 1'b0;
    logic prst_n = 1'b1;
    logic ft = 1'b0;
    logic async_r = 1'b0;
    logic [1:0] width = 2'h0;
    logic oe_n = 1'b0;
    logic mark = 1'b0;
    logic sclk = 1'b0;
    logic sen_n = 1'b1;
    logic ld_cfg_n = 1'b0;
    logic wr_valid = 1'b0;
    logic [DATA_W-1:0] wr_data = '0;
    int ef_lows = 0;
    logic ok = 1'b0;
    logic rclk, ren_n, rcs_n, rt, ld_n, oe_out, wr_ready, ef_n, ff_n, ae_n, af_n;
    logic [DATA_W-1:0] rdata, q;
    int bits;
    int n;
    int errors = 0;
    int num_checks = 0;
    always #4 clk = ~clk;
    always @(posedge clk) if (!ef_n) ef_lows <= ef_lows + 1;
    frp_read_port u_dut (
        .ref_clk_in(clk), .rstn_in(rstn),
        .master_reset_n_in(mrst_n), .partial_reset_n_in(prst_n),
        .fall_through_mode_in(ft), .async_read_in(async_r), .read_width_in(width),
        .read_clock_in(rclk), .read_enable_n_in(ren_n), .read_select_n_in(rcs_n),
        .output_enable_n_in(oe_n), .retransmit_in(rt), .mark_in(mark),
        .offset_access_n_in(ld_n & ld_cfg_n), .read_data_out(rdata),
        .read_data_oe_out(oe_out), .serial_clock_in(sclk), .offset_shift_enable_n_in(sen_n),
        .wr_valid_in(wr_valid), .wr_ready_out(wr_ready), .wr_data_in(wr_data),
        .empty_flag_n_out(ef_n), .full_flag_n_out(ff_n),
        .almost_empty_n_out(ae_n), .almost_full_n_out(af_n)
    );
    frp_reader_model u_rd (
        .ref_clk_in(clk), .async_in(async_r), .read_clock_out(rclk),
        .read_enable_n_out(ren_n), .read_select_n_out(rcs_n), .retransmit_out(rt),
        .offset_access_n_out(ld_n), .read_data_in(rdata)
    );
    task automatic conclude();
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    task automatic rd(input logic en_n, input logic sel_n, input logic r, input logic o);
        u_rd.read(en_n, sel_n, r, o, q);
    endtask : rd
    task automatic wr(input logic [DATA_W-1:0] d);
        int k;
        k = 0;
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_data <= d;
        @(posedge clk);
        while (wr_ready !== 1'b1 && k < 20) begin
            k++;
            @(posedge clk);
        end
        ok = (wr_ready === 1'b1);
        wr_valid <= 1'b0;
    endtask : wr
    task automatic mrst(input logic f, input logic a, input logic [1:0] w);
        @(posedge clk);
        ft <= f;
        async_r <= a;
        width <= w;
        ld_cfg_n <= 1'b0;
        mrst_n <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK("mrst q", 36'h0, rdata)
        `CHK("mrst oe", H, oe_out)
        mrst_n <= 1'b1;
        repeat (4) @(posedge clk);
        ld_cfg_n <= 1'b1;
        ft <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : mrst
    task automatic shift(input logic b, input logic en);
        @(posedge clk);
        ft <= b;
        sen_n <= en;
        repeat (4) @(posedge clk);
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
        sclk <= 1'b0;
    endtask : shift
    initial begin
        #500000;
        errors++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        mrst(L, L, WIDTH_36);
        `CHK("ef rst", L, ef_n)
        foreach (ROWS[i]) wr(ROWS[i].wdata);
        repeat (10) @(posedge clk);
        foreach (ROWS[i]) begin
            rd(L, L, L, H);
            `CHK("row", ROWS[i].rdata, q)
        end
        rd(L, L, L, H);
        `CHK("empty read", ROWS[3].rdata, q)
        wr(36'h5_0000_0005);
        repeat (10) @(posedge clk);
        rd(L, H, L, H);
        `CHK("desel q", ROWS[3].rdata, q)
        `CHK("desel oe", L, oe_out)
        rd(H, L, L, H);
        `CHK("ren off", ROWS[3].rdata, q)
        rd(L, L, L, H);
        `CHK("sel q", 36'h5_0000_0005, q)
        wr(36'h0_0000_00B0);
        wr(36'h0_0000_00C0);
        repeat (10) @(posedge clk);
        rd(L, L, L, H);
        `CHK("b", 36'h0_0000_00B0, q)
        n = ef_lows;
        rd(H, L, H, H);
        `CHK("rt empty", H, ef_lows > n)
        rd(L, L, L, H);
        `CHK("rt zero", ROWS[0].rdata, q)
        rd(L, L, L, H);
        @(posedge clk);
        mark <= 1'b1;
        repeat (4) @(posedge clk);
        mark <= 1'b0;
        repeat (4) @(posedge clk);
        rd(L, L, L, H);
        `CHK("after mark", ROWS[2].rdata, q)
        rd(H, L, H, H);
        rd(L, L, L, H);
        `CHK("rt mark", ROWS[2].rdata, q)
        for (int i = 0; i < 2; i++) begin
            rd(L, L, L, L);
            `CHK("ofs", ({26'h0, (i == 0) ? EMPTY_OFS_RST : FULL_OFS_RST}), q)
        end
        for (int i = 19; i >= 0; i--) shift(SER[i], L);
        for (int i = 0; i < 3; i++) shift(H, H);
        repeat (6) @(posedge clk);
        for (int i = 0; i < 2; i++) begin
            rd(L, L, L, L);
            `CHK("ser ofs", ({26'h0, (i == 0) ? SER[19:10] : SER[9:0]}), q)
        end
        rd(L, H, L, H);
        @(posedge clk);
        prst_n <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK("prst q", 36'h0, rdata)
        `CHK("prst oe", H, oe_out)
        oe_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("prst oe off", L, oe_out)
        oe_n <= 1'b0;
        prst_n <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK("prst ef", L, ef_n)
        for (int i = 1; i <= 3; i++) wr(DATA_W'(i));
        repeat (10) @(posedge clk);
        `CHK("ae kept", H, ae_n)
        rd(L, L, L, H);
        `CHK("prst first", 36'h1, q)
        rd(L, L, L, H);
        repeat (4) @(posedge clk);
        `CHK("ae low", L, ae_n)
        rd(L, L, L, H);
        `CHK("std kept", 36'h3, q)
        n = 0;
        ok = 1'b1;
        while (ok && n < 1100) begin
            wr(DATA_W'(n));
            if (ok) n++;
        end
        repeat (10) @(posedge clk);
        `CHK("fill", H, n == DEPTH + STAGE_DEPTH)
        `CHK("full", L, ff_n)
        `CHK("afull", L, af_n)
        `CHK("refuse", L, wr_ready)
        for (int i = 0; i < n; i++) begin
            rd(L, L, L, H);
            `CHK("wrap", DATA_W'(i), q)
        end
        `CHK("drained", L, ef_n)
        foreach (MODES[m]) begin
            mrst(L, MODES[m][2], MODES[m][1:0]);
            wr(WORD);
            repeat (10) @(posedge clk);
            bits = (MODES[m][1:0] == WIDTH_18) ? 18 : (MODES[m][1:0] == WIDTH_9) ? 9 : 36;
            for (int k = 0; k < 36 / bits; k++) begin
                rd(L, L, L, H);
                `CHK("piece", (WORD >> (k * bits)) & ({DATA_W{1'b1}} >> (DATA_W - bits)), q)
            end
        end
        // fall-through: words appear without a read, retransmit reloads the first
        mrst(H, L, WIDTH_36);
        `CHK("ft idle", H, ef_n)
        wr(WORD);
        wr(36'h0_0000_0ABC);
        repeat (10) @(posedge clk);
        `CHK("ft word", WORD, rdata)
        `CHK("ft ready", L, ef_n)
        rd(L, L, L, H);
        `CHK("ft next", 36'h0_0000_0ABC, rdata)
        rd(L, L, L, H);
        `CHK("ft drained", H, ef_n)
        rd(H, L, H, H);
        `CHK("ft rt word", WORD, rdata)
        `CHK("ft rt ready", L, ef_n)
        conclude();
    end
endmodule : frp_read_port_tb
`default_nettype wire
